/* rtl/handler_state_control.sv */
/*
 * Handler state bits 13..0: pending and active state of the system
 * exceptions, one copy per security state where banked, one shared
 * copy elsewhere, with a word read/write port from the system space.
 * Assumes access attributes, settings and exception events all come
 * from logic on i_clk_sys, and that only word accesses arrive.
 */
// Functional notes
// [RULE1] bit 13 shows and sets memory-protection pending, per security state
// [RULE2] bit 12 shows and sets instruction-misuse pending, per security state
// [RULE3] bit 11 tick active, banked only when two tick timers exist
// [RULE4] single timer: tick bit owned by secure or non-secure per select
// [RULE5] bit 10 deferred service active, banked, software writable
// [RULE6] bit 8 debug watch active shared, hidden from non-secure by monitor
// [RULE7] bit 7 supervisor call active, banked, software writable
// [RULE8] bit 5 nonmaskable active shared; non-secure view gated by fault target
// [RULE9] nonmaskable active ignores set, non-secure, no alias, locked debug
// [RULE10] nonmaskable active cleared only by secure access through the alias
// [RULE11] bit 4 security violation active shared, hidden from non-secure
// [RULE12] bit 3 instruction-misuse active, banked, software writable
// [RULE13] bit 2 escalated fault active banked, only partly writable
// [RULE14] escalated ignores set, secure copy, non-secure, locked debugger
// [RULE15] bit 1 bus error active shared; fault target gates non-secure view
// [RULE16] bit 0 memory-protection active, banked, software writable
// [RULE17] without main extension several bits read as zero
// [RULE18] warm reset clears every bit
// [RULE19] hardware sets pending on occurrence, clears it on activation
// [RULE20] hardware sets active bit when exception becomes active
// [RULE21] software uses privileged word accesses only
// [RULE22] bits 9 and 6 read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none

module handler_state_control
	import hsc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_acc_rd,
	input wire logic i_acc_wr,
	input wire logic [`HSC_DATA_W-1:0] i_acc_wdata,
	input wire logic i_acc_from_ns,
	input wire logic i_acc_via_alias,
	input wire logic i_acc_debugger,
	input wire logic i_main_ext,
	input wire logic [1:0] i_tick_timers,
	input wire logic i_timer_security_select,
	input wire logic i_secure_debug_monitor_enable,
	input wire logic i_fault_target_nonsecure,
	input wire logic i_secure_debug_enabled,
	input wire logic [`HSC_W-1:0] i_hw_set_s,
	input wire logic [`HSC_W-1:0] i_hw_set_ns,
	input wire logic [`HSC_W-1:0] i_hw_clr_s,
	input wire logic [`HSC_W-1:0] i_hw_clr_ns,
	output logic [`HSC_DATA_W-1:0] o_acc_rdata,
	output logic o_acc_rvalid,
	output logic [`HSC_W-1:0] o_state_s,
	output logic [`HSC_W-1:0] o_state_ns
);
	hsc_bits_t state_s_reg, state_s_next;
	hsc_bits_t state_ns_reg, state_ns_next;
	hsc_bits_t sw_s, sw_ns;
	hsc_bits_t set_s, set_ns, clr_s, clr_ns;
	hsc_bits_t keep_s, keep_ns;
	hsc_bits_t view;
	logic [`HSC_DATA_W-1:0] rdata_reg, rdata_next;
	logic rvalid_reg;

	hsc_view_if v ();

	// next value of one bank: software write, then clears, sets last
	function automatic hsc_bits_t bank_next(
		input hsc_bits_t cur,
		input hsc_bits_t sw,
		input hsc_bits_t wd,
		input hsc_bits_t clr,
		input hsc_bits_t set,
		input hsc_bits_t keep
	);
		hsc_bits_t all_clr;
		all_clr = clr;
		// activation takes the pending state away
		all_clr[`HSC_MEM_PEND] = clr[`HSC_MEM_PEND] | set[`HSC_MEM_ACT];
		all_clr[`HSC_MIS_PEND] = clr[`HSC_MIS_PEND] | set[`HSC_MIS_ACT];
		// set wins so an event in the clearing cycle is kept
		return ((((cur & ~sw) | (wd & sw)) & ~all_clr) | set) & keep;
	endfunction

	// access attributes and settings go to the decoder
	assign v.from_ns = i_acc_from_ns;
	assign v.via_alias = i_acc_via_alias;
	assign v.debugger = i_acc_debugger;
	assign v.wdata = i_acc_wdata[`HSC_W-1:0];
	assign v.tick_timers = i_tick_timers;
	assign v.timer_security_select = i_timer_security_select;
	assign v.secure_debug_monitor_enable = i_secure_debug_monitor_enable;
	assign v.fault_target_nonsecure = i_fault_target_nonsecure;
	assign v.secure_debug_enabled = i_secure_debug_enabled;
	assign v.main_ext = i_main_ext;

	hsc_view_decode u_decode (
		.v(v.decode)
	);

	// software write masks: shared bits always live in the secure copy
	always_comb begin
		sw_s = `HSC_ZERO;
		sw_ns = `HSC_ZERO;
		if (i_acc_wr) begin
			sw_s = v.wr_mask & (v.target_ns ? ~v.banked : `HSC_ALL);
			sw_ns = v.wr_mask & (v.target_ns ? v.banked : `HSC_ZERO);
		end
	end

	// hardware events: shared bits fold into the secure copy
	assign set_s = i_hw_set_s | (i_hw_set_ns & ~v.banked); // RULE19 RULE20
	assign set_ns = i_hw_set_ns & v.banked; // RULE19 RULE20
	assign clr_s = i_hw_clr_s | (i_hw_clr_ns & ~v.banked);
	assign clr_ns = i_hw_clr_ns & v.banked;

	// bits that may hold a one at all in each copy
	always_comb begin
		keep_s = `HSC_ALL & ~`HSC_RESV_MASK; // RULE22
		if (!i_main_ext) begin
			keep_s = keep_s & ~`HSC_MAINONLY_MASK; // RULE17
		end
		keep_ns = keep_s & v.banked;
	end

	assign state_s_next = bank_next(state_s_reg, sw_s, v.wdata, clr_s,
		set_s, keep_s); // RULE1 RULE2 RULE5 RULE7 RULE12 RULE16
	assign state_ns_next = bank_next(state_ns_reg, sw_ns, v.wdata, clr_ns,
		set_ns, keep_ns); // RULE1 RULE2 RULE5 RULE7 RULE12 RULE16

	// secure copy and all shared bits
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_s_reg <= `HSC_RESET; // RULE18
		end else begin
			state_s_reg <= state_s_next;
		end
	end

	// non-secure copy of the banked bits
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ns_reg <= `HSC_RESET; // RULE18
		end else begin
			state_ns_reg <= state_ns_next;
		end
	end

	// read view: banked bits from the chosen copy, shared from secure
	assign view = v.target_ns ?
		((state_ns_reg & v.banked) | (state_s_reg & ~v.banked)) :
		state_s_reg;
	assign rdata_next = i_acc_rd ?
		{{`HSC_PAD_W{1'b0}}, view & v.rd_mask} : rdata_reg;

	// read data held until the next read; one-cycle valid strobe
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next; // RULE6 RULE8 RULE11 RULE15 RULE22
			rvalid_reg <= i_acc_rd;
		end
	end

	assign o_acc_rdata = rdata_reg;
	assign o_acc_rvalid = rvalid_reg;
	assign o_state_s = state_s_reg;
	assign o_state_ns = state_ns_reg;

	// checks on the state and the read port
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);

	logic hw_quiet;
	assign hw_quiet = ~|{i_hw_set_s, i_hw_set_ns, i_hw_clr_s, i_hw_clr_ns};

	property p_mem_act_write;
		i_acc_wr && !i_acc_from_ns && !i_acc_via_alias && i_main_ext &&
			hw_quiet
		|=> state_s_reg[`HSC_MEM_ACT] == $past(i_acc_wdata[`HSC_MEM_ACT]);
	endproperty
	a_mem_act_write: assert property (p_mem_act_write) // RULE16
		else $error("secure write to protect active not stored");

	property p_nmi_no_sw_set;
		$rose(state_s_reg[`HSC_NMI_ACT])
		|-> $past(i_hw_set_s[`HSC_NMI_ACT] | i_hw_set_ns[`HSC_NMI_ACT]);
	endproperty
	a_nmi_no_sw_set: assert property (p_nmi_no_sw_set) // RULE9
		else $error("nonmaskable active set without an event");

	property p_nmi_clear_path;
		$fell(state_s_reg[`HSC_NMI_ACT])
		|-> $past((i_acc_wr && i_acc_via_alias && !i_acc_from_ns &&
			i_fault_target_nonsecure &&
			!(i_acc_debugger && !i_secure_debug_enabled)) ||
			i_hw_clr_s[`HSC_NMI_ACT] || i_hw_clr_ns[`HSC_NMI_ACT]);
	endproperty
	a_nmi_clear_path: assert property (p_nmi_clear_path) // RULE10
		else $error("nonmaskable active cleared by a barred access");

	property p_esc_secure_kept;
		$fell(state_s_reg[`HSC_ESC_ACT]) |-> $past(i_hw_clr_s[`HSC_ESC_ACT]);
	endproperty
	a_esc_secure_kept: assert property (p_esc_secure_kept) // RULE14
		else $error("secure escalated active changed by software");

	property p_sec_hidden;
		i_acc_rd && i_acc_from_ns |=> o_acc_rvalid && !o_acc_rdata[`HSC_SEC_ACT];
	endproperty
	a_sec_hidden: assert property (p_sec_hidden) // RULE11
		else $error("security violation bit visible to non-secure");

	property p_resv_zero;
		o_acc_rvalid |-> o_acc_rdata[`HSC_DATA_W-1:`HSC_W] == '0 &&
			(o_acc_rdata[`HSC_W-1:0] & `HSC_RESV_MASK) == `HSC_ZERO;
	endproperty
	a_resv_zero: assert property (p_resv_zero) // RULE22
		else $error("reserved bits read non-zero");

	property p_no_main_ext;
		!i_main_ext ##1 !i_main_ext
		|-> (state_s_reg & `HSC_MAINONLY_MASK) == `HSC_ZERO;
	endproperty
	a_no_main_ext: assert property (p_no_main_ext) // RULE17
		else $error("main-extension bit held without the extension");

	property p_pend_cleared;
		i_hw_set_s[`HSC_MEM_ACT] && !i_hw_set_s[`HSC_MEM_PEND]
		|=> !state_s_reg[`HSC_MEM_PEND] ##1 1'b1;
	endproperty
	a_pend_cleared: assert property (p_pend_cleared) // RULE19
		else $error("pending not cleared on activation");

	property p_svc_set_ns;
		i_hw_set_ns[`HSC_SVC_ACT] |=> state_ns_reg[`HSC_SVC_ACT];
	endproperty
	a_svc_set_ns: assert property (p_svc_set_ns) // RULE20
		else $error("active bit not set on activation");

	property p_nmi_ns_view;
		i_acc_rd && i_acc_from_ns && !i_fault_target_nonsecure
		|=> !o_acc_rdata[`HSC_NMI_ACT];
	endproperty
	a_nmi_ns_view: assert property (p_nmi_ns_view) // RULE8
		else $error("nonmaskable bit visible to non-secure");

	property p_dbg_hidden;
		i_acc_rd && i_acc_from_ns && i_secure_debug_monitor_enable
		|=> !o_acc_rdata[`HSC_DBG_ACT];
	endproperty
	a_dbg_hidden: assert property (p_dbg_hidden) // RULE6
		else $error("debug watch bit visible to non-secure");

	property p_tick_owner;
		i_acc_rd && (i_tick_timers < `HSC_TWO_TIMERS) && !i_acc_from_ns &&
			!i_acc_via_alias && i_timer_security_select
		|=> !o_acc_rdata[`HSC_TICK_ACT];
	endproperty
	a_tick_owner: assert property (p_tick_owner) // RULE4
		else $error("tick bit seen by the state that does not own it");

	// reserved positions must never hold state in either copy
	property p_resv_state;
		((state_s_reg | state_ns_reg) & `HSC_RESV_MASK) == `HSC_ZERO;
	endproperty
	a_resv_state: assert property (p_resv_state) // RULE22
		else $error("reserved state bit holds a one");

	// only a secure alias clear or a return may drop the non-secure copy
	property p_esc_ns_clear;
		$fell(state_ns_reg[`HSC_ESC_ACT])
		|-> $past((i_acc_wr && i_acc_via_alias && !i_acc_from_ns &&
			!(i_acc_debugger && !i_secure_debug_enabled)) ||
			i_hw_clr_ns[`HSC_ESC_ACT]);
	endproperty
	a_esc_ns_clear: assert property (p_esc_ns_clear) // RULE13
		else $error("non-secure escalated active cleared by a barred access");

	property p_pend_set;
		i_hw_set_s[`HSC_MEM_PEND] && i_main_ext
		|=> state_s_reg[`HSC_MEM_PEND];
	endproperty
	a_pend_set: assert property (p_pend_set) // RULE1
		else $error("protect pending not set by its event");

	// alias from non-secure is read-as-zero, so it is left out here
	property p_svc_ns_write;
		i_acc_wr && i_acc_from_ns && !i_acc_via_alias && hw_quiet
		|=> state_ns_reg[`HSC_SVC_ACT] == $past(i_acc_wdata[`HSC_SVC_ACT]);
	endproperty
	a_svc_ns_write: assert property (p_svc_ns_write) // RULE7
		else $error("non-secure write to call active not stored");

	// one cycle of grace: a stale copy is masked off the edge after
	property p_tick_unbanked;
		(i_tick_timers < `HSC_TWO_TIMERS) ##1
		(i_tick_timers < `HSC_TWO_TIMERS) |-> !state_ns_reg[`HSC_TICK_ACT];
	endproperty
	a_tick_unbanked: assert property (p_tick_unbanked) // RULE3
		else $error("tick active kept in a non-secure copy with one timer");

	cover property (i_acc_wr && i_acc_via_alias && !i_acc_from_ns
		##1 $fell(state_s_reg[`HSC_NMI_ACT]));
	cover property ($fell(state_ns_reg[`HSC_ESC_ACT]) && hw_quiet);
	cover property (i_hw_set_s[`HSC_MEM_ACT] && state_s_reg[`HSC_MEM_PEND]);
	cover property (i_acc_rd && i_acc_via_alias ##1 o_acc_rdata != '0);
endmodule

`default_nettype wire

/* rtl/hsc_cfg.svh */
/*
 * Constants for the handler state bits block: field positions, masks,
 * reset value and access-port widths.
 * Assumes it is included by bare name wherever these names are used.
 */
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

`define HSC_W 14
`define HSC_DATA_W 32
`define HSC_PAD_W 18
`define HSC_RESET 14'h0000
`define HSC_ALL 14'h3fff
`define HSC_ZERO 14'h0000

// field positions
`define HSC_MEM_PEND 13
`define HSC_MIS_PEND 12
`define HSC_TICK_ACT 11
`define HSC_DSR_ACT 10
`define HSC_DBG_ACT 8
`define HSC_SVC_ACT 7
`define HSC_NMI_ACT 5
`define HSC_SEC_ACT 4
`define HSC_MIS_ACT 3
`define HSC_ESC_ACT 2
`define HSC_BUS_ACT 1
`define HSC_MEM_ACT 0

// bits with a copy per security state (tick bit added when two timers)
`define HSC_BANKED_MASK 14'h348d
// bits that exist only with the main extension
`define HSC_MAINONLY_MASK 14'h310b
// reserved bits 9 and 6
`define HSC_RESV_MASK 14'h0240
// tick timer count at which the tick bit becomes banked
`define HSC_TWO_TIMERS 2'h2

`endif

/* rtl/hsc_pkg.sv */
/*
 * Types shared by the handler state bits modules.
 * Assumes hsc_cfg.svh is on the include path.
 */
`include "hsc_cfg.svh"

package hsc_pkg;
	typedef logic [`HSC_W-1:0] hsc_bits_t;
	typedef logic [1:0] hsc_timers_t;
endpackage

/* rtl/hsc_view_decode.sv */
/*
 * Access view decoder: picks the security bank that an access sees and
 * works out which bits it may read and which it may change.
 * Assumes the settings are stable around an access; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module hsc_view_decode
	import hsc_pkg::*;
(
	hsc_view_if.decode v
);
	logic two_timers;
	logic ns_blocked_dbg;

	assign two_timers = (v.tick_timers >= `HSC_TWO_TIMERS);
	// alias access or non-secure caller sees the non-secure copy
	assign v.target_ns = v.from_ns | v.via_alias;
	// debugger without secure debug may not clear the two guarded bits
	assign ns_blocked_dbg = v.debugger & ~v.secure_debug_enabled;

	// tick bit is banked only with two timers
	always_comb begin
		v.banked = `HSC_BANKED_MASK;
		v.banked[`HSC_TICK_ACT] = two_timers; // RULE3
	end

	// visible bits for this access
	always_comb begin
		v.rd_mask = `HSC_ALL & ~`HSC_RESV_MASK; // RULE22
		if (!v.main_ext) begin
			v.rd_mask = v.rd_mask & ~`HSC_MAINONLY_MASK; // RULE17
		end
		// a single timer belongs to one state only
		if (!two_timers && (v.timer_security_select != v.target_ns)) begin
			v.rd_mask[`HSC_TICK_ACT] = 1'b0; // RULE4
		end
		if (v.from_ns && v.secure_debug_monitor_enable) begin
			v.rd_mask[`HSC_DBG_ACT] = 1'b0; // RULE6
		end
		if (v.target_ns && !v.fault_target_nonsecure) begin
			v.rd_mask[`HSC_NMI_ACT] = 1'b0; // RULE8
		end
		if (v.from_ns) begin
			v.rd_mask[`HSC_SEC_ACT] = 1'b0; // RULE11
		end
		if (v.from_ns && !v.fault_target_nonsecure) begin
			v.rd_mask[`HSC_BUS_ACT] = 1'b0; // RULE15
		end
		// alias is zero to non-secure code and to the debugger
		if (v.via_alias && (v.from_ns || v.debugger)) begin
			v.rd_mask = `HSC_ZERO;
		end
	end

	// writable bits: visible ones, with clear-only guards on two of them
	always_comb begin
		v.wr_mask = v.rd_mask;
		v.wr_mask[`HSC_NMI_ACT] = v.rd_mask[`HSC_NMI_ACT] &
			~v.wdata[`HSC_NMI_ACT] & v.fault_target_nonsecure &
			~v.from_ns & v.via_alias & ~ns_blocked_dbg; // RULE9 RULE10
		v.wr_mask[`HSC_ESC_ACT] = v.rd_mask[`HSC_ESC_ACT] &
			~v.wdata[`HSC_ESC_ACT] & v.target_ns &
			~v.from_ns & ~ns_blocked_dbg; // RULE13 RULE14
	end
endmodule

`default_nettype wire

/* rtl/hsc_view_if.sv */
/*
 * Carrier between the state core and the access view decoder: the
 * access attributes and settings go out, the bank choice and the
 * read and write masks come back.
 * Assumes both ends run on the same clock and are purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

interface hsc_view_if;
	import hsc_pkg::*;
	logic from_ns;
	logic via_alias;
	logic debugger;
	hsc_bits_t wdata;
	hsc_timers_t tick_timers;
	logic timer_security_select;
	logic secure_debug_monitor_enable;
	logic fault_target_nonsecure;
	logic secure_debug_enabled;
	logic main_ext;
	logic target_ns;
	hsc_bits_t banked;
	hsc_bits_t rd_mask;
	hsc_bits_t wr_mask;

	modport core (
		output from_ns, via_alias, debugger, wdata, tick_timers,
		output timer_security_select, secure_debug_monitor_enable,
		output fault_target_nonsecure, secure_debug_enabled, main_ext,
		input target_ns, banked, rd_mask, wr_mask
	);
	modport decode (
		input from_ns, via_alias, debugger, wdata, tick_timers,
		input timer_security_select, secure_debug_monitor_enable,
		input fault_target_nonsecure, secure_debug_enabled, main_ext,
		output target_ns, banked, rd_mask, wr_mask
	);
endinterface

`default_nettype wire

/* verif/handler_state_control_tb.sv */
/*
 * Self-checking bench for the handler state bits block: banked and
 * shared bits, hidden views, restricted clears, tick ownership, missing
 * main extension, hardware events and warm reset.
 * Assumes rtl/ on the include path and a 40 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hsc_cfg.svh"

`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) begin \
			failures++; \
			$display("[ERR] %s exp %h got %h", nm, e, g); \
		end \
	end

module handler_state_control_tb
	import hsc_pkg::*;
();
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic acc_rd = 1'b0;
	logic acc_wr = 1'b0;
	logic [`HSC_DATA_W-1:0] acc_wdata = '0;
	logic from_ns = 1'b0;
	logic via_alias = 1'b0;
	logic dbg = 1'b0;
	logic main_ext = 1'b1;
	logic [1:0] timers = 2'h2;
	logic tss = 1'b0;
	logic sdme = 1'b0;
	logic ftn = 1'b1;
	logic sde = 1'b1;
	hsc_bits_t set_s = '0;
	hsc_bits_t set_ns = '0;
	hsc_bits_t clr_s = '0;
	hsc_bits_t clr_ns = '0;
	logic [`HSC_DATA_W-1:0] rdata;
	logic rvalid;
	hsc_bits_t st_s;
	hsc_bits_t st_ns;
	logic [31:0] got;
	int failures = 0;
	int n_compared = 0;

	handler_state_control uut (
		.i_clk_sys(clk_sys),
		.i_nrst(nrst),
		.i_acc_rd(acc_rd),
		.i_acc_wr(acc_wr),
		.i_acc_wdata(acc_wdata),
		.i_acc_from_ns(from_ns),
		.i_acc_via_alias(via_alias),
		.i_acc_debugger(dbg),
		.i_main_ext(main_ext),
		.i_tick_timers(timers),
		.i_timer_security_select(tss),
		.i_secure_debug_monitor_enable(sdme),
		.i_fault_target_nonsecure(ftn),
		.i_secure_debug_enabled(sde),
		.i_hw_set_s(set_s),
		.i_hw_set_ns(set_ns),
		.i_hw_clr_s(clr_s),
		.i_hw_clr_ns(clr_ns),
		.o_acc_rdata(rdata),
		.o_acc_rvalid(rvalid),
		.o_state_s(st_s),
		.o_state_ns(st_ns)
	);

	// free-running clock, 25 ns period
	always #12.5 clk_sys = ~clk_sys;

	task automatic summarize();
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic st(input hsc_bits_t es, input hsc_bits_t en);
		`CHK("state_s", es, st_s)
		`CHK("state_ns", en, st_ns)
	endtask

	// one-cycle write; upper word bits set to prove they are ignored
	task automatic wr(input logic ns, al, db, input hsc_bits_t d);
		@(negedge clk_sys);
		{from_ns, via_alias, dbg} = {ns, al, db};
		acc_wdata = {{`HSC_PAD_W{1'b1}}, d};
		acc_wr = 1'b1;
		@(negedge clk_sys);
		acc_wr = 1'b0;
	endtask

	// read answers one cycle later and rvalid drops the cycle after
	task automatic rd(input logic ns, al, db, output logic [31:0] q);
		@(negedge clk_sys);
		{from_ns, via_alias, dbg} = {ns, al, db};
		acc_rd = 1'b1;
		@(negedge clk_sys);
		acc_rd = 1'b0;
		`CHK("rvalid", 1'b1, rvalid)
		q = rdata;
		@(negedge clk_sys);
		`CHK("rvalid_low", 1'b0, rvalid)
	endtask

	task automatic hw(input hsc_bits_t ss, sn, cs, cn);
		@(negedge clk_sys);
		{set_s, set_ns, clr_s, clr_ns} = {ss, sn, cs, cn};
		@(negedge clk_sys);
		{set_s, set_ns, clr_s, clr_ns} = '0;
	endtask

	// warm reset, whatever state the previous scenario left behind
	task automatic do_reset();
		@(negedge clk_sys);
		nrst = 1'b0;
		{main_ext, timers, tss, sdme, ftn, sde} = {1'b1, 2'h2, 4'h3};
		repeat (4) @(negedge clk_sys);
		`CHK("rst_state_s", 14'h0000, st_s)
		`CHK("rst_state_ns", 14'h0000, st_ns)
		nrst = 1'b1;
	endtask

	task automatic t_banked();
		do_reset();
		wr(0, 0, 0, 14'h3fff);
		st(14'h3d9b, 14'h0000);
		rd(0, 0, 0, got);
		`CHK("rd_s", 32'h00003d9b, got)
		wr(1, 0, 0, 14'h3fff);
		st(14'h3d9b, 14'h3c89);
		rd(1, 0, 0, got);
		`CHK("rd_ns", 32'h00003d8b, got)
		wr(1, 0, 0, 14'h0000);
		st(14'h3c99, 14'h0000);
	endtask

	task automatic t_hide();
		do_reset();
		hw(14'h0132, 14'h0000, 14'h0000, 14'h0000);
		st(14'h0132, 14'h0000);
		sdme = 1'b1;
		ftn = 1'b0;
		rd(1, 0, 0, got);
		`CHK("rd_hidden", 32'h00000000, got)
		wr(1, 0, 0, 14'h0000);
		st(14'h0132, 14'h0000);
		sdme = 1'b0;
		ftn = 1'b1;
		rd(1, 0, 0, got);
		`CHK("rd_shown", 32'h00000122, got)
		wr(1, 0, 0, 14'h0000);
		st(14'h0030, 14'h0000);
	endtask

	// restricted clears of the nonmaskable and escalated bits
	task automatic t_restricted();
		do_reset();
		wr(0, 1, 0, 14'h0024);
		st(14'h0000, 14'h0000);
		hw(14'h0024, 14'h0004, 14'h0000, 14'h0000);
		wr(0, 0, 0, 14'h0000);
		st(14'h0024, 14'h0004);
		wr(1, 0, 0, 14'h0000);
		st(14'h0024, 14'h0004);
		sde = 1'b0;
		wr(0, 1, 1, 14'h0000);
		st(14'h0024, 14'h0004);
		sde = 1'b1;
		ftn = 1'b0;
		wr(0, 1, 0, 14'h0004);
		st(14'h0024, 14'h0004);
		ftn = 1'b1;
		wr(0, 1, 0, 14'h0000);
		st(14'h0004, 14'h0000);
	endtask

	task automatic t_tick();
		do_reset();
		timers = 2'h1;
		wr(0, 0, 0, 14'h0800);
		st(14'h0800, 14'h0000);
		rd(1, 0, 0, got);
		`CHK("tick_ns_off", 32'h00000000, got)
		tss = 1'b1;
		rd(1, 0, 0, got);
		`CHK("tick_ns_on", 32'h00000800, got)
		rd(0, 0, 0, got);
		`CHK("tick_s_off", 32'h00000000, got)
		wr(1, 0, 0, 14'h0000);
		st(14'h0000, 14'h0000);
		timers = 2'h2;
		hw(14'h0000, 14'h0800, 14'h0000, 14'h0000);
		st(14'h0000, 14'h0800);
	endtask

	task automatic t_noext();
		do_reset();
		main_ext = 1'b0;
		wr(0, 0, 0, 14'h3fff);
		st(14'h0c90, 14'h0000);
		hw(14'h3fff, 14'h3fff, 14'h0000, 14'h0000);
		st(14'h0cb4, 14'h0c84);
	endtask

	// pending set, then activation clears it; set beats clear
	task automatic t_events();
		do_reset();
		hw(14'h2000, 14'h0000, 14'h0000, 14'h0000);
		st(14'h2000, 14'h0000);
		hw(14'h0001, 14'h0000, 14'h0000, 14'h0000);
		st(14'h0001, 14'h0000);
		hw(14'h0000, 14'h1008, 14'h0000, 14'h0000);
		st(14'h0001, 14'h1008);
		hw(14'h0000, 14'h0400, 14'h0000, 14'h0400);
		st(14'h0001, 14'h1408);
		hw(14'h0000, 14'h0000, 14'h0001, 14'h1408);
		st(14'h0000, 14'h0000);
	endtask

	// watchdog in case anything hangs
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		summarize();
	end

	initial begin
		t_banked();
		t_hide();
		t_restricted();
		t_tick();
		t_noext();
		t_events();
		do_reset();
		summarize();
	end
endmodule

`default_nettype wire
